// >>> lpcg_ctrl.v
`timescale 1ns/1ps
`include "lpcg_defines.vh"
// Contract
// - Idle gates CPU logic, clock output runs in mode 00 only
// - Reset or interrupt ends sleep; halt ends only on reset or protect pins
// - Separate CPU and system clock gates
// - Mode field bits 13:12 picks sleep
// - Mode 00 stops CPU domain only
// - Mode 01 stops CPU and system
// - Mode 1X also stops watchdog, PLL, oscillator
// - Peripheral clock enables clear at reset
module lpcg_ctrl #(
  parameter STAB_CYC = `LPCG_STAB_CYC
) (
  input wire ref_clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire idle_exec,
  input wire periph_irq,
  input wire wakeup_irq,
  input wire ext_irq_pin,
  input wire power_drive_protect_inputs,
  output reg cpu_clk_en,
  output reg sys_clk_en,
  output reg cpu_clock_output_en,
  output reg watchdog_clock_en,
  output reg pll_en,
  output reg osc_en,
  output reg [5:0] periph_clk_en,
  output reg cpu_idle
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_RUN = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_HALT = 2'd2;
  localparam ST_RESTART = 2'd3;
  // Run: CPU clocked, gates open
  // Sleep: light or deep sleep, oscillator kept alive
  // Halt: oscillator, PLL and watchdog clock off
  // Restart: oscillator back on, domains still gated
  // A wake from halt always passes through restart, so the CPU never
  // sees a clock from an oscillator that has not settled; reset goes straight to run

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] mode_q;
  reg [1:0] sleep_mode_q;
  reg [1:0] sleep_mode_d;
  reg [5:0] pclk_q;
  reg [31:0] stab_q;
  reg [31:0] stab_d;
  wire [1:0] pin_sync;
  wire ext_irq_s;
  wire pdp_s;
  wire wake;
  wire wr_en;
  wire rd_en;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pins are asynchronous to ref_clk
  lpcg_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .async_in({ext_irq_pin, power_drive_protect_inputs}),
    .sync_out(pin_sync)
  );
  assign ext_irq_s = pin_sync[1];
  assign pdp_s = pin_sync[0];

  // ****************************************************************
  // Wake decode
  // ****************************************************************
  // Wake set per mode; halt hears only protect pins
  function wake_for;
    input [1:0] m;
    input pi;
    input wi;
    input ei;
    input pd;
    begin
      if (m == `LPCG_MODE_LIGHT) begin
        wake_for = pi | ei | pd;
      end else if (m == `LPCG_MODE_DEEP) begin
        wake_for = wi | ei | pd;
      end else begin
        wake_for = pd;
      end
    end
  endfunction

  // Reset wakes by forcing state to run
  assign wake = wake_for(sleep_mode_q, periph_irq, wakeup_irq, ext_irq_s,
                         pdp_s);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state; pready rises the cycle after the access cycle starts
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;

  // Control word select, shared by read and write paths
  function is_ctrl_addr;
    input [11:0] a;
    begin
      is_ctrl_addr = (a == `LPCG_SCS1_ADDR);
    end
  endfunction

  // Status word select, shared by read and write paths
  function is_stat_addr;
    input [11:0] a;
    begin
      is_stat_addr = (a == `LPCG_STAT_ADDR);
    end
  endfunction

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      mode_q <= 2'b00;
      pclk_q <= 6'b00_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      // Writes outside the control word are refused
      if (wr_en) begin
        if (is_ctrl_addr(paddr)) begin
          mode_q <= pwdata[`LPCG_LPM_HI:`LPCG_LPM_LO];
          pclk_q <= pwdata[`LPCG_EN_ADC:`LPCG_EN_EVA];
        end else if (is_stat_addr(paddr)) begin
          pslverr <= 1'b1; // Status is read only
        end else begin
          pslverr <= 1'b1;
        end
      end
      // Read data stands only in the answer cycle
      if (rd_en) begin
        if (is_ctrl_addr(paddr)) begin
          prdata <= {18'h0_0000, mode_q, 4'h0, pclk_q, 2'b00};
        end else if (is_stat_addr(paddr)) begin
          prdata <= {28'h000_0000, sleep_mode_q, state_q};
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  // Mode latched at idle so later writes cannot alter sleep
  always @* begin
    state_d = state_q;
    sleep_mode_d = sleep_mode_q;
    stab_d = stab_q;
    case (state_q)
      ST_RUN: begin
        if (idle_exec) begin
          sleep_mode_d = mode_q;
          if (mode_q[1]) begin
            state_d = ST_HALT;
          end else begin
            state_d = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_d = ST_RESTART;
          stab_d = 32'd0;
        end
      end
      default: begin
        // Domains stay gated until oscillator and PLL settle
        if (stab_q >= STAB_CYC - 1) begin
          state_d = ST_RUN;
        end else begin
          stab_d = stab_q + 32'd1;
        end
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RUN;
      sleep_mode_q <= 2'b00;
      stab_q <= 32'd0;
    end else begin
      state_q <= state_d;
      sleep_mode_q <= sleep_mode_d;
      stab_q <= stab_d;
    end
  end

  // ****************************************************************
  // Clock gate outputs
  // ****************************************************************
  // Next-state views shared by the gate registers
  wire run_d;
  wire sys_on_d;
  assign run_d = (state_d == ST_RUN);
  // System domain runs in run and light sleep only
  assign sys_on_d = run_d |
                    (state_d == ST_SLEEP &&
                     sleep_mode_d == `LPCG_MODE_LIGHT);

  // One gate per peripheral; each needs its enable bit
  // and a running system domain, so deep sleep and halt win over enable
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pclk
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          periph_clk_en[gi] <= 1'b0;
        end else begin
          periph_clk_en[gi] <= pclk_q[gi] & sys_on_d;
        end
      end
    end
  endgenerate

  // Registered from next state so gates move with the state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      cpu_clock_output_en <= 1'b1;
      watchdog_clock_en <= 1'b1;
      pll_en <= 1'b1;
      osc_en <= 1'b1;
      cpu_idle <= 1'b0;
    end else begin
      cpu_clk_en <= run_d;
      sys_clk_en <= sys_on_d;
      // Clock output only stops when the system domain does
      cpu_clock_output_en <= sys_on_d;
      watchdog_clock_en <= (state_d != ST_HALT);
      pll_en <= (state_d != ST_HALT);
      osc_en <= (state_d != ST_HALT);
      cpu_idle <= ~run_d;
    end
  end
  // Flash power is software's job before halt; no flash gate here
endmodule

// >>> lpcg_defines.vh
`ifndef LPCG_DEFINES_VH
`define LPCG_DEFINES_VH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define LPCG_SCS1_ADDR 12'h000
`define LPCG_STAT_ADDR 12'h004
// ****************************************************************
// Field positions in system_control_status_one
// ****************************************************************
`define LPCG_LPM_HI 13
`define LPCG_LPM_LO 12
`define LPCG_EN_ADC 7
`define LPCG_EN_SCI 6
`define LPCG_EN_SPI 5
`define LPCG_EN_CAN 4
`define LPCG_EN_EVB 3
`define LPCG_EN_EVA 2
`define LPCG_SCS1_RST 32'h0000_0000
`define LPCG_SCS1_WMASK 32'h0000_30FC
// ****************************************************************
// Mode codes
// ****************************************************************
`define LPCG_MODE_LIGHT 2'b00
`define LPCG_MODE_DEEP 2'b01
// ****************************************************************
// Timing: oscillator and PLL restart after halt
// ****************************************************************
`define LPCG_STAB_NS 20000
`define LPCG_CLK_NS 4
`define LPCG_STAB_CYC ((`LPCG_STAB_NS + `LPCG_CLK_NS - 1) / `LPCG_CLK_NS)
`endif

// >>> lpcg_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser bank for asynchronous pins
module lpcg_sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// >>> lpcg_cpu_model.sv
`timescale 1ns/1ps
// ****
// CPU core model
// ****
module lpcg_cpu_model (
  input wire ref_clk,
  input wire arst_n,
  input wire idle_req,
  input wire halt_next,
  output logic idle_exec,
  output logic flash_off
);
  logic req_q;
  // One idle pulse per request; flash is off before a halt
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= 1'b0;
      idle_exec <= 1'b0;
      flash_off <= 1'b0;
    end else begin
      req_q <= idle_req;
      idle_exec <= idle_req & ~req_q;
      flash_off <= halt_next;
    end
  end
endmodule

// >>> lpcg_ctrl_asserts.sv
`timescale 1ns/1ps
// ****
// Sleep controller checks
// ****
module lpcg_ctrl_chk #(
  parameter STAB_CYC = 8
) (
  input wire ref_clk,
  input wire arst_n,
  input wire idle_exec,
  input wire periph_irq,
  input wire power_drive_protect_inputs,
  input wire cpu_clk_en,
  input wire sys_clk_en,
  input wire cpu_clock_output_en,
  input wire watchdog_clock_en,
  input wire pll_en,
  input wire osc_en,
  input wire [5:0] periph_clk_en,
  input wire cpu_idle
);
  // One domain, so one clock and reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_IDLE: assert property (
    idle_exec && !cpu_idle |=> !cpu_clk_en && cpu_idle)
    else $error("idle left cpu domain on");
  AST_LIGHT: assert property (
    cpu_idle && sys_clk_en |-> cpu_clock_output_en && osc_en && pll_en)
    else $error("light sleep stopped too much");
  AST_DEEP: assert property (
    !cpu_clk_en && osc_en |-> pll_en && watchdog_clock_en)
    else $error("pll or watchdog off with osc on");
  AST_HALT: assert property (
    !osc_en |-> !pll_en && !watchdog_clock_en && !sys_clk_en)
    else $error("halt left a clock running");
  AST_WAKE: assert property (
    cpu_idle && sys_clk_en && periph_irq |=> cpu_clk_en && !cpu_idle)
    else $error("interrupt did not wake");
  AST_HALT_HOLD: assert property (
    (!osc_en && !power_drive_protect_inputs)[*3] |=> !osc_en)
    else $error("halt left without a wake source");
  AST_RESTART: assert property (
    $rose(osc_en) |-> (!cpu_clk_en && !sys_clk_en)[*8] ##[1:4] cpu_clk_en)
    else $error("clocks back before settling");
  AST_PCE_RST: assert property (
    $rose(arst_n) |-> periph_clk_en == 6'h00)
    else $error("peripheral clocks on after reset");
  cover property (cpu_idle && sys_clk_en);
  cover property (cpu_idle && !sys_clk_en && osc_en);
  cover property ($rose(osc_en));
endmodule
bind lpcg_ctrl lpcg_ctrl_chk #(.STAB_CYC(STAB_CYC)) u_lpcg_ctrl_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .idle_exec(idle_exec),
  .periph_irq(periph_irq),
  .power_drive_protect_inputs(power_drive_protect_inputs),
  .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
  .cpu_clock_output_en(cpu_clock_output_en),
  .watchdog_clock_en(watchdog_clock_en), .pll_en(pll_en),
  .osc_en(osc_en), .periph_clk_en(periph_clk_en), .cpu_idle(cpu_idle));

// >>> tb_top.sv
`timescale 1ns/1ps
`include "lpcg_defines.vh"
// ****
// Sleep controller bench
// ****
module tb_top;
  logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, idle_req = 1'b0, halt_next = 1'b0;
  logic [3:0] wake = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, ie, fl, cpu, sys, co, wd, pll, osc, idl;
  logic [5:0] pce;
  int failures = 0, check_count = 0, n;
  // Rows: mode, wake source, asleep {system, clock out, osc}
  logic [6:0] rows [6] = '{7'h07, 7'h17, 7'h29, 7'h31, 7'h58, 7'h78};
  wire [6:0] gates = {cpu, idl, sys, co, osc, pll, wd};
  // Free-running clock
  always #2 ref_clk = ~ref_clk;
  lpcg_ctrl #(.STAB_CYC(8)) u_lpcg_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_exec(ie), .periph_irq(wake[0]), .wakeup_irq(wake[1]),
    .ext_irq_pin(wake[2]), .power_drive_protect_inputs(wake[3]),
    .cpu_clk_en(cpu), .sys_clk_en(sys), .cpu_clock_output_en(co),
    .watchdog_clock_en(wd), .pll_en(pll), .osc_en(osc),
    .periph_clk_en(pce), .cpu_idle(idl));
  lpcg_cpu_model u_lpcg_cpu_model (.ref_clk(ref_clk), .arst_n(arst_n),
    .idle_req(idle_req), .halt_next(halt_next), .idle_exec(ie),
    .flash_off(fl));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
    @(posedge ref_clk);
  endtask
  task automatic run(input int lim);
    n = 0;
    while (cpu !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (cpu !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask
  // Mode plus all peripheral clocks, then idle
  task automatic sleep(input logic [1:0] m);
    halt_next <= m[1];
    apb(1'b1, `LPCG_SCS1_ADDR, {18'h0_0000, m, 12'h0FC});
    idle_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    idle_req <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    cmp(32'(pce), 32'h0);
    apb(1'b1, `LPCG_SCS1_ADDR, 32'h0000_30FC);
    cmp(32'(pce), 32'h3F);
    apb(1'b0, `LPCG_SCS1_ADDR, 32'h0);
    cmp(rd, 32'h0000_30FC);
    apb(1'b0, 12'h008, 32'h0);
    cmp(32'(err), 32'h1);
    apb(1'b1, `LPCG_STAT_ADDR, 32'h0);
    cmp(32'(err), 32'h1);
    foreach (rows[i]) begin
      sleep(rows[i][6:5]);
      cmp(32'(gates), 32'({2'b01, rows[i][2:0], {2{rows[i][0]}}}));
      cmp(32'(pce), 32'({6{rows[i][2]}}));
      cmp(32'(fl), 32'(rows[i][6]));
      wake <= 4'h1 << rows[i][4:3];
      run(40);
      cmp(32'(gates), 32'h5F);
      if (rows[i][6]) cmp(32'(n >= 8), 32'h1);
      wake <= 4'h0;
      repeat (4) @(posedge ref_clk);
    end
    sleep(2'b01);
    wake <= 4'h1;
    repeat (6) @(posedge ref_clk);
    cmp(32'(cpu), 32'h0);
    wake <= 4'h2;
    run(40);
    wake <= 4'h0;
    sleep(2'b00);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    cmp(32'({gates, pce}), 32'h17C0);
    give_verdict();
  end
endmodule
